// File: verification/fpmc_front_panel_asserts.sv
`default_nettype none
module fpmc_front_panel_asserts
    import fpmc_pkg::*;
(
    // Clock, reset and status
    input wire logic ref_clk, rstn, temp_at_limit, sensor_open, cooler_ilimit, cooler_vlimit, booster_in_use,
    input wire logic remote_limit_shutdown_enable, cooler_on_req,
    input wire logic [15:0] photodiode_responsivity,
    // Outputs watched
    input wire logic cooler_enable, temp_limit_lamp, cooler_ilimit_lamp, cooler_module_open_lamp,
    input wire logic signed [15:0] sensor_const_one,
    input wire fpmc_mode_e laser_mode,
    input wire fpmc_target_e laser_target,
    input wire logic laser_on, laser_on_lamp, output_short, output_short_lamp
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    property p_limit_off;
        temp_at_limit && remote_limit_shutdown_enable |=> !cooler_enable;
    endproperty
    a_limit_off: assert property (p_limit_off) else $error("limit shutdown");
    property p_cooler_on;
        cooler_on_req && !sensor_open && !temp_at_limit |=> cooler_enable;
    endproperty
    a_cooler_on: assert property (p_cooler_on) else $error("cooler not on");
    property p_sensor_off;
        sensor_open |=> !cooler_enable;
    endproperty
    a_sensor_off: assert property (p_sensor_off) else $error("sensor shutdown");
    property p_temp_lamp;
        !temp_at_limit |=> !temp_limit_lamp;
    endproperty
    a_temp_lamp: assert property (p_temp_lamp) else $error("limit lamp");
    property p_ilim_lamp;
        !cooler_ilimit && !cooler_vlimit |=> !cooler_ilimit_lamp;
    endproperty
    a_ilim_lamp: assert property (p_ilim_lamp) else $error("ilimit lamp");
    property p_module_lamp;
        booster_in_use |=> !cooler_module_open_lamp;
    endproperty
    a_module_lamp: assert property (p_module_lamp) else $error("module lamp");
    property p_const_range;
        sensor_const_one >= CONST_MIN && sensor_const_one <= CONST_MAX;
    endproperty
    a_const_range: assert property (p_const_range) else $error("const range");
    property p_mode_step;
        $past(rstn) && $changed(laser_mode) |-> laser_mode == (($past(laser_mode) == FPMC_MODE_FAST) ?
            FPMC_MODE_CURRENT : fpmc_mode_e'($past(laser_mode) + 2'h1));
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode out of order");
    property p_target;
        laser_target == ((laser_mode != FPMC_MODE_POWER) ? FPMC_TGT_CURRENT :
            (photodiode_responsivity != 16'h0000) ? FPMC_TGT_PD_POWER : FPMC_TGT_PD_CURRENT);
    endproperty
    a_target: assert property (p_target) else $error("wrong set point");
    property p_short;
        output_short == !laser_on && output_short_lamp == !laser_on && laser_on_lamp == laser_on;
    endproperty
    a_short: assert property (p_short) else $error("short lamps");
endmodule : fpmc_front_panel_asserts
bind fpmc_front_panel fpmc_front_panel_asserts i_asserts (.*);
`default_nettype wire

// File: verification/fpmc_operator.sv
`default_nettype none
module fpmc_operator #(
    parameter int HOLD = 12
) (
    // Clock
    input wire logic ref_clk,
    // Switches, knob, adjust selection
    output logic param_select_sw, param_set_sw, laser_mode_sw, laser_on_sw, knob_up, knob_down, laser_adjust_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] sw = 7'h00;
    assign {laser_adjust_sel, knob_down, knob_up, laser_on_sw, laser_mode_sw, param_set_sw, param_select_sw} = sw;
    task automatic press(input int i);
        @(negedge ref_clk);
        sw[i] = 1'b1;
        repeat (HOLD) @(negedge ref_clk);
        sw[i] = 1'b0;
        repeat (HOLD) @(negedge ref_clk);
    endtask : press
    task automatic level(input int i, input logic v);
        @(negedge ref_clk);
        sw[i] = v;
        repeat (HOLD) @(negedge ref_clk);
    endtask : level
endmodule : fpmc_operator
`default_nettype wire

// File: verification/tb_front_panel_mode_controller.sv
`default_nettype none
`define CHK(w, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("mismatch %s expected %0h seen %0h", w, e, g); \
    end end
module tb_front_panel_mode_controller
    import fpmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int B1 = 8, B2 = 4;
    localparam int SEL = 0, SET = 1, MODE = 2, ON = 3, UP = 4, DN = 5, ADJ = 6;
    logic ref_clk, rstn, param_select_sw, param_set_sw, laser_mode_sw, laser_on_sw, laser_adjust_sel;
    logic knob_up, knob_down, temp_at_limit, sensor_open, cooler_ilimit, cooler_vlimit, cooler_module_open;
    logic booster_in_use, remote_limit_shutdown_enable, linear_sensor, cooler_on_req;
    logic signed [15:0] cooler_current_pct, sensor_const_one, sensor_const_two, sensor_const_three;
    logic [15:0] photodiode_responsivity;
    logic [5:0] st;
    assign {booster_in_use, cooler_module_open, cooler_vlimit, cooler_ilimit, sensor_open, temp_at_limit} = st;
    logic cooler_enable, temp_limit_lamp, sensor_open_lamp, cooler_ilimit_lamp, cooler_module_open_lamp;
    logic [BAR_W-1:0] bar_pos, bar_neg;
    logic select_active, const_lamp, nv_commit, current_mode_lamp, power_mode_lamp, fast_current_mode_lamp;
    logic laser_on, laser_on_lamp, output_short, output_short_lamp;
    logic [5:0] param_lamp;
    logic [8:0] loop_gain;
    logic [2:0] knob_ilimit_step, knob_tlimit_step;
    fpmc_param_e param_sel;
    fpmc_mode_e laser_mode;
    fpmc_target_e laser_target;
    int n_mismatch = 0, samples_checked = 0, n_commit = 0;
    wire logic [3:0] lamps = {cooler_module_open_lamp, cooler_ilimit_lamp, sensor_open_lamp, temp_limit_lamp};
    wire logic [3:0] las = {laser_on, laser_on_lamp, output_short, output_short_lamp};
    wire logic [2:0] mlamp = {current_mode_lamp, power_mode_lamp, fast_current_mode_lamp};
    fpmc_front_panel #(.DEBOUNCE_CYCLES(4), .SELECT_TIMEOUT_CYCLES(50), .BLINK1_CYCLES(B1),
        .BLINK2_CYCLES(B2)) i_dut (.*);
    fpmc_operator i_op (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (nv_commit === 1'b1) n_commit++;
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic done(input string s);
        $display("test %s done, mismatches %0d", s, n_mismatch);
    endtask : done
    task automatic stat(input logic [5:0] v);
        @(negedge ref_clk);
        st = v;
        repeat (3) @(negedge ref_clk);
    endtask : stat
    task automatic cooler_blink;
        logic signed [15:0] pct [3] = '{16'sh001e, 16'sh0000, 16'sh0064};
        logic [9:0] bar [3] = '{10'h007, 10'h000, 10'h3ff};
        logic [5:0] cv [6] = '{6'h01, 6'h02, 6'h04, 6'h0c, 6'h10, 6'h30};
        int li [6] = '{0, 1, 2, 2, 3, 3};
        int ex [6] = '{64 / B1, 64 / B1, 64 / B1, 64 / B2, 64 / B1, 0};
        int n;
        logic p;
        cooler_on_req = 1'b1;
        remote_limit_shutdown_enable = 1'b1;
        for (int k = 0; k < 3; k++) begin
            cooler_current_pct = pct[k];
            stat(6'h00);
            `CHK("bar_pos", bar[k], bar_pos)
        end
        cooler_current_pct = -16'sh0019;
        stat(6'h00);
        `CHK("bar polarity", 2'h1, {|bar_pos, |bar_neg})
        stat(6'h01);
        `CHK("cooler at limit", 1'b0, cooler_enable)
        remote_limit_shutdown_enable = 1'b0;
        stat(6'h01);
        `CHK("no shutdown", 1'b1, cooler_enable)
        stat(6'h02);
        `CHK("sensor open", 1'b0, cooler_enable)
        cooler_on_req = 1'b0;
        for (int k = 0; k < 6; k++) begin
            stat(cv[k]);
            n = 0;
            p = lamps[li[k]];
            repeat (64) begin
                @(negedge ref_clk);
                n += int'(lamps[li[k]] !== p);
                p = lamps[li[k]];
            end
            `CHK("blink edges", ex[k], n)
        end
        stat(6'h00);
        done("cooler");
    endtask : cooler_blink
    task automatic params;
        logic [8:0] gl [6] = '{GAIN_3, GAIN_10, GAIN_30, GAIN_100, GAIN_300, GAIN_300};
        for (int k = 0; k < 7; k++) begin
            i_op.press(SEL);
            `CHK("param_sel", fpmc_param_e'(k % 6), param_sel)
            `CHK("param_lamp", 6'h01 << (k % 6), param_lamp)
            `CHK("const_lamp", 1'(k inside {[2:4]}), const_lamp)
            if (k inside {[2:4]}) `CHK("bar const", 10'h001 << (k - 2), bar_pos)
        end
        repeat (30) @(negedge ref_clk);
        `CHK("select held", 1'b1, select_active)
        repeat (40) @(negedge ref_clk);
        `CHK("select timeout", 1'b0, select_active)
        `CHK("gain reset", GAIN_1, loop_gain)
        repeat (6) i_op.press(SEL);
        i_op.level(SET, 1'b1);
        for (int k = 0; k < 6; k++) begin
            i_op.press(UP);
            `CHK("gain step", gl[k], loop_gain)
        end
        i_op.press(DN);
        i_op.level(SET, 1'b0);
        i_op.press(DN);
        `CHK("gain kept", GAIN_100, loop_gain)
        `CHK("commit", 1, n_commit)
        repeat (80) @(negedge ref_clk);
        repeat (3) i_op.press(SEL);
        i_op.level(SET, 1'b1);
        i_op.press(UP);
        `CHK("const one", 16'sh0001, sensor_const_one)
        i_op.level(SET, 1'b0);
        repeat (2) i_op.press(SEL);
        linear_sensor = 1'b1;
        i_op.level(SET, 1'b1);
        i_op.press(UP);
        `CHK("const three", 16'sh0000, sensor_const_three)
        i_op.level(SET, 1'b0);
        linear_sensor = 1'b0;
        `CHK("commits", 3, n_commit)
        repeat (80) @(negedge ref_clk);
        done("params");
    endtask : params
    task automatic laser;
        fpmc_mode_e me [4] = '{FPMC_MODE_POWER, FPMC_MODE_FAST, FPMC_MODE_CURRENT, FPMC_MODE_POWER};
        logic [2:0] ml [4] = '{3'h2, 3'h1, 3'h4, 3'h2};
        fpmc_target_e mt [4] = '{FPMC_TGT_PD_CURRENT, FPMC_TGT_CURRENT, FPMC_TGT_CURRENT, FPMC_TGT_PD_POWER};
        i_op.press(MODE);
        `CHK("mode ignored", FPMC_MODE_CURRENT, laser_mode)
        i_op.level(ADJ, 1'b1);
        i_op.press(SEL);
        `CHK("select refused", 1'b0, select_active)
        for (int k = 0; k < 4; k++) begin
            photodiode_responsivity = 16'(k == 3);
            i_op.press(MODE);
            `CHK("mode", me[k], laser_mode)
            `CHK("mode lamps", ml[k], mlamp)
            `CHK("target", mt[k], laser_target)
        end
        for (int k = 0; k < 3; k++) begin
            i_op.press(ON);
            `CHK("laser", (k % 2 == 0) ? 4'hc : 4'h3, las)
        end
        rstn = 1'b0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        `CHK("laser reset", 4'h3, las)
        `CHK("mode reset", 3'h4, mlamp)
        done("laser");
    endtask : laser
    initial begin
        rstn = 1'b0;
        {st, remote_limit_shutdown_enable, linear_sensor, cooler_on_req, cooler_current_pct, photodiode_responsivity} = '0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        `CHK("laser power-up", 4'h3, las)
        cooler_blink();
        params();
        laser();
        end_of_test();
    end
endmodule : tb_front_panel_mode_controller
`default_nettype wire

// File: verilog/fpmc_blink.sv
`default_nettype none
module fpmc_blink #(
    parameter int HALF1_CYC = 50_000_000,
    parameter int HALF2_CYC = 25_000_000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Square waves, fifty percent duty
    output logic blink_1hz,
    output logic blink_2hz
);
    logic [$clog2(HALF1_CYC)-1:0] cnt1;
    logic [$clog2(HALF2_CYC)-1:0] cnt2;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt1 <= '0;
            blink_1hz <= 1'b0;
        end else if (cnt1 == ($clog2(HALF1_CYC))'(HALF1_CYC - 1)) begin
            cnt1 <= '0;
            blink_1hz <= !blink_1hz;
        end else begin
            cnt1 <= cnt1 + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt2 <= '0;
            blink_2hz <= 1'b0;
        end else if (cnt2 == ($clog2(HALF2_CYC))'(HALF2_CYC - 1)) begin
            cnt2 <= '0;
            blink_2hz <= !blink_2hz;
        end else begin
            cnt2 <= cnt2 + 1'b1;
        end
    end
endmodule : fpmc_blink
`default_nettype wire

// File: verilog/fpmc_debounce.sv
`default_nettype none
module fpmc_debounce #(
    parameter int STABLE_CYC = 1_000_000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Raw switch and result
    input wire logic raw,
    output logic level,
    output logic press,
    output logic release_pulse
);
    logic [2:0] sync;
    logic [$clog2(STABLE_CYC+1)-1:0] cnt;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], raw};
        end
    end

    // Change counts only when second and third stages agree and hold
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt <= '0;
            level <= 1'b0;
            press <= 1'b0;
            release_pulse <= 1'b0;
        end else begin
            press <= 1'b0;
            release_pulse <= 1'b0;
            if (sync[1] != sync[2] || sync[2] == level) begin
                cnt <= '0;
            end else if (cnt == ($clog2(STABLE_CYC+1))'(STABLE_CYC - 1)) begin
                cnt <= '0;
                level <= sync[2];
                press <= sync[2];
                release_pulse <= !sync[2];
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule : fpmc_debounce
`default_nettype wire

// File: verilog/fpmc_front_panel.sv
`default_nettype none
// How it works
// RULE1 - temperature at upper limit turns cooler off unless remote shutdown is disabled
// RULE2 - temperature limit lamp blinks at one hertz while limit is active
// RULE3 - open sensor turns cooler off and blinks sensor-open lamp at one hertz
// RULE4 - cooler current limit blinks the current-limit lamp at one hertz
// RULE5 - compliance voltage limit blinks the same lamp at two hertz
// RULE6 - open module blinks its lamp at one hertz, not with booster source
// RULE7 - hold set switch and turn knob; commit value on set release
// RULE8 - the three sensor constants stay within -9.999 to +9.999
// RULE9 - constants selected lights constants lamp and one bar segment
// RULE10 - linear sensor type uses only first two constants
// RULE11 - gain takes only 1, 3, 10, 30, 100, 300, stepped in order
// RULE12 - cooler on: bar graph shows current as percent of limit, both polarities
// RULE13 - exactly one laser mode is active at all times
// RULE14 - mode switch cycles current, power, fast current, lighting one lamp
// RULE15 - power mode with nonzero responsivity regulates to photodiode power
// RULE16 - power mode with zero responsivity regulates to photodiode current
// RULE17 - both current modes regulate to the shared current set point
// RULE18 - laser adjust selection must be active; mode changes otherwise ignored
// RULE19 - laser off asserts internal short and lights shorted lamp
// RULE20 - laser on switch toggles output; on lamp follows output
// RULE21 - laser stays off after power-up until first on press
// RULE22 - parameter select cycles current limit, temp limit, C one-three, gain
// RULE23 - selection ends three seconds after select release with no action
// RULE24 - blink enables come from a clock divider at fifty percent duty
// RULE25 - every switch except laser_adjust_sel is debounced and each press acts once
module fpmc_front_panel
    import fpmc_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int SELECT_TIMEOUT_CYCLES = SELECT_TIMEOUT_CYC,
    parameter int BLINK1_CYCLES = BLINK1_HALF_CYC,
    parameter int BLINK2_CYCLES = BLINK2_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Front panel switches and knob
    input wire logic param_select_sw,
    input wire logic param_set_sw,
    input wire logic laser_mode_sw,
    input wire logic laser_on_sw,
    input wire logic laser_adjust_sel,
    input wire logic knob_up,
    input wire logic knob_down,
    // Cooler status from analog side
    input wire logic temp_at_limit,
    input wire logic sensor_open,
    input wire logic cooler_ilimit,
    input wire logic cooler_vlimit,
    input wire logic cooler_module_open,
    input wire logic booster_in_use,
    input wire logic remote_limit_shutdown_enable,
    input wire logic linear_sensor,
    input wire logic cooler_on_req,
    input wire logic signed [15:0] cooler_current_pct,
    input wire logic [15:0] photodiode_responsivity,
    // Cooler outputs and lamps
    output logic cooler_enable,
    output logic temp_limit_lamp,
    output logic sensor_open_lamp,
    output logic cooler_ilimit_lamp,
    output logic cooler_module_open_lamp,
    output logic [BAR_W-1:0] bar_pos,
    output logic [BAR_W-1:0] bar_neg,
    // Parameter selection and stored values
    output logic select_active,
    output fpmc_pkg::fpmc_param_e param_sel,
    output logic [5:0] param_lamp,
    output logic const_lamp,
    output logic nv_commit,
    output logic signed [15:0] sensor_const_one,
    output logic signed [15:0] sensor_const_two,
    output logic signed [15:0] sensor_const_three,
    output logic [8:0] loop_gain,
    output logic [2:0] knob_ilimit_step,
    output logic [2:0] knob_tlimit_step,
    // Laser mode and output
    output fpmc_pkg::fpmc_mode_e laser_mode,
    output logic current_mode_lamp,
    output logic power_mode_lamp,
    output logic fast_current_mode_lamp,
    output fpmc_pkg::fpmc_target_e laser_target,
    output logic laser_on,
    output logic laser_on_lamp,
    output logic output_short,
    output logic output_short_lamp
);
    import fpmc_pkg::*;

    localparam int NSW = 6;
    localparam int TW = $clog2(SELECT_TIMEOUT_CYCLES + 1);

    logic [NSW-1:0] sw_raw;
    logic [NSW-1:0] sw_lvl;
    logic [NSW-1:0] sw_press;
    logic [NSW-1:0] sw_rel;
    logic blink_1hz;
    logic blink_2hz;
    logic [TW-1:0] sel_timer;
    logic [2:0] gain_idx;
    logic signed [15:0] next_const;
    logic signed [15:0] cur_const;
    logic knob_step;

    assign sw_raw = {knob_down, knob_up, laser_on_sw, laser_mode_sw, param_set_sw, param_select_sw};

    genvar gi;
    generate
        for (gi = 0; gi < NSW; gi++) begin : g_deb
            fpmc_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_deb ( // see RULE25
                .ref_clk(ref_clk),
                .rstn(rstn),
                .raw(sw_raw[gi]),
                .level(sw_lvl[gi]),
                .press(sw_press[gi]),
                .release_pulse(sw_rel[gi])
            );
        end
    endgenerate

    fpmc_blink #(.HALF1_CYC(BLINK1_CYCLES), .HALF2_CYC(BLINK2_CYCLES)) u_blink ( // see RULE24
        .ref_clk(ref_clk),
        .rstn(rstn),
        .blink_1hz(blink_1hz),
        .blink_2hz(blink_2hz)
    );

    // Knob only acts while set switch is held in selection
    assign knob_step = select_active && sw_lvl[1] && (sw_press[4] || sw_press[5]);

    // Cooler enable and fault shutdown
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cooler_enable <= 1'b0;
        end else begin
            cooler_enable <= cooler_on_req && !sensor_open // see RULE3
                && !(temp_at_limit && remote_limit_shutdown_enable); // see RULE1
        end
    end

    // Fault lamps
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            temp_limit_lamp <= 1'b0;
            sensor_open_lamp <= 1'b0;
            cooler_ilimit_lamp <= 1'b0;
            cooler_module_open_lamp <= 1'b0;
        end else begin
            temp_limit_lamp <= temp_at_limit && blink_1hz; // see RULE2
            sensor_open_lamp <= sensor_open && blink_1hz; // see RULE3
            if (cooler_vlimit) begin
                cooler_ilimit_lamp <= blink_2hz; // see RULE5
            end else begin
                cooler_ilimit_lamp <= cooler_ilimit && blink_1hz; // see RULE4
            end
            cooler_module_open_lamp <= cooler_module_open && !booster_in_use && blink_1hz; // see RULE6
        end
    end

    // Parameter selection and timeout
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            select_active <= 1'b0;
            param_sel <= FPMC_PAR_ILIM;
            sel_timer <= '0;
        end else if (sw_press[0] && !laser_adjust_sel) begin
            sel_timer <= '0;
            if (!select_active) begin
                select_active <= 1'b1;
                param_sel <= FPMC_PAR_ILIM;
            end else begin
                case (param_sel) // see RULE22
                    FPMC_PAR_ILIM: param_sel <= FPMC_PAR_TLIM;
                    FPMC_PAR_TLIM: param_sel <= FPMC_PAR_C1;
                    FPMC_PAR_C1: param_sel <= FPMC_PAR_C2;
                    FPMC_PAR_C2: param_sel <= FPMC_PAR_C3;
                    FPMC_PAR_C3: param_sel <= FPMC_PAR_GAIN;
                    default: param_sel <= FPMC_PAR_ILIM;
                endcase
            end
        end else if (select_active) begin
            if (sw_lvl[0] || sw_lvl[1] || sw_rel[1]) begin
                sel_timer <= '0;
            end else if (sel_timer == TW'(SELECT_TIMEOUT_CYCLES - 1)) begin
                select_active <= 1'b0; // see RULE23
                sel_timer <= '0;
            end else begin
                sel_timer <= sel_timer + 1'b1;
            end
        end
    end

    always_comb begin
        param_lamp = '0;
        if (select_active) begin
            param_lamp[param_sel] = 1'b1;
        end
    end
    assign const_lamp = select_active
        && (param_sel == FPMC_PAR_C1 || param_sel == FPMC_PAR_C2 || param_sel == FPMC_PAR_C3); // see RULE9

    // Commit on release of the set switch
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            nv_commit <= 1'b0;
        end else begin
            nv_commit <= select_active && sw_rel[1]; // see RULE7
        end
    end

    // Constant edit with clamp
    always_comb begin
        case (param_sel)
            FPMC_PAR_C1: cur_const = sensor_const_one;
            FPMC_PAR_C2: cur_const = sensor_const_two;
            default: cur_const = sensor_const_three;
        endcase
        next_const = cur_const;
        if (sw_press[4] && cur_const < CONST_MAX) begin
            next_const = cur_const + 16'sh0001; // see RULE8
        end else if (sw_press[5] && cur_const > CONST_MIN) begin
            next_const = cur_const - 16'sh0001; // see RULE8
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sensor_const_one <= CONST_RESET;
            sensor_const_two <= CONST_RESET;
            sensor_const_three <= CONST_RESET;
        end else if (knob_step) begin // see RULE7
            if (param_sel == FPMC_PAR_C1) begin
                sensor_const_one <= next_const;
            end
            if (param_sel == FPMC_PAR_C2) begin
                sensor_const_two <= next_const;
            end
            if (param_sel == FPMC_PAR_C3 && !linear_sensor) begin
                sensor_const_three <= next_const; // see RULE10
            end
        end
    end

    // Gain steps through its discrete ladder
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gain_idx <= GAIN_IDX_RESET;
        end else if (knob_step && param_sel == FPMC_PAR_GAIN) begin
            if (sw_press[4] && gain_idx < GAIN_IDX_MAX) begin
                gain_idx <= gain_idx + 3'h1; // see RULE11
            end else if (sw_press[5] && gain_idx != GAIN_IDX_RESET) begin
                gain_idx <= gain_idx - 3'h1;
            end
        end
    end

    always_comb begin
        case (gain_idx) // see RULE11
            3'h0: loop_gain = GAIN_1;
            3'h1: loop_gain = GAIN_3;
            3'h2: loop_gain = GAIN_10;
            3'h3: loop_gain = GAIN_30;
            3'h4: loop_gain = GAIN_100;
            default: loop_gain = GAIN_300;
        endcase
    end

    // Limit value knob steps go to the analog side
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            knob_ilimit_step <= 3'h0;
            knob_tlimit_step <= 3'h0;
        end else begin
            knob_ilimit_step <= {knob_step && param_sel == FPMC_PAR_ILIM, sw_press[4], sw_press[5]};
            knob_tlimit_step <= {knob_step && param_sel == FPMC_PAR_TLIM, sw_press[4], sw_press[5]};
        end
    end

    // Bar graph: constant index, or current percentage
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bar_pos <= '0;
            bar_neg <= '0;
        end else if (const_lamp) begin
            bar_neg <= '0;
            bar_pos <= BAR_W'(1) << (param_sel - FPMC_PAR_C1); // see RULE9
        end else if (cooler_enable) begin
            for (int i = 0; i < BAR_W; i++) begin // see RULE12
                bar_pos[i] <= cooler_current_pct > 16'(i * 100 / BAR_W);
                bar_neg[i] <= -cooler_current_pct > 16'(i * 100 / BAR_W);
            end
        end else begin
            bar_pos <= '0;
            bar_neg <= '0;
        end
    end

    // Laser mode select, only with laser adjust active
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            laser_mode <= FPMC_MODE_CURRENT;
        end else if (sw_press[2] && laser_adjust_sel) begin // see RULE18
            case (laser_mode) // see RULE14
                FPMC_MODE_CURRENT: laser_mode <= FPMC_MODE_POWER;
                FPMC_MODE_POWER: laser_mode <= FPMC_MODE_FAST;
                default: laser_mode <= FPMC_MODE_CURRENT; // see RULE13
            endcase
        end
    end

    assign current_mode_lamp = laser_mode == FPMC_MODE_CURRENT; // see RULE13
    assign power_mode_lamp = laser_mode == FPMC_MODE_POWER;
    assign fast_current_mode_lamp = laser_mode == FPMC_MODE_FAST;

    always_comb begin
        case (laser_mode)
            FPMC_MODE_POWER: laser_target = (photodiode_responsivity != 16'h0000)
                ? FPMC_TGT_PD_POWER : FPMC_TGT_PD_CURRENT; // see RULE15 see RULE16
            default: laser_target = FPMC_TGT_CURRENT; // see RULE17
        endcase
    end

    // Laser output toggle, off from reset
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            laser_on <= 1'b0; // see RULE21
        end else if (sw_press[3]) begin
            laser_on <= !laser_on; // see RULE20
        end
    end

    assign laser_on_lamp = laser_on; // see RULE20
    assign output_short = !laser_on; // see RULE19
    assign output_short_lamp = !laser_on;
endmodule : fpmc_front_panel
`default_nettype wire

// File: verilog/fpmc_pkg.sv
`default_nettype none
package fpmc_pkg;
    localparam int CLK_HZ = 100_000_000;
    // Blink half periods for 1 Hz and 2 Hz, fifty percent duty
    localparam int BLINK1_HALF_MS = 500;
    localparam int BLINK2_HALF_MS = 250;
    localparam int BLINK1_HALF_CYC = CLK_HZ / 1000 * BLINK1_HALF_MS;
    localparam int BLINK2_HALF_CYC = CLK_HZ / 1000 * BLINK2_HALF_MS;
    localparam int SELECT_TIMEOUT_MS = 3000;
    localparam int SELECT_TIMEOUT_CYC = CLK_HZ / 1000 * SELECT_TIMEOUT_MS;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    // Sensor constants in thousandths, signed
    localparam logic signed [15:0] CONST_MAX = 16'sh270f;
    localparam logic signed [15:0] CONST_MIN = -16'sh270f;
    localparam logic signed [15:0] CONST_RESET = 16'sh0000;
    localparam logic [2:0] GAIN_IDX_MAX = 3'h5;
    localparam logic [2:0] GAIN_IDX_RESET = 3'h0;
    localparam logic [8:0] GAIN_1 = 9'h001;
    localparam logic [8:0] GAIN_3 = 9'h003;
    localparam logic [8:0] GAIN_10 = 9'h00a;
    localparam logic [8:0] GAIN_30 = 9'h01e;
    localparam logic [8:0] GAIN_100 = 9'h064;
    localparam logic [8:0] GAIN_300 = 9'h12c;
    localparam int BAR_W = 10;

    typedef enum logic [2:0] {
        FPMC_PAR_ILIM = 3'h0,
        FPMC_PAR_TLIM = 3'h1,
        FPMC_PAR_C1 = 3'h2,
        FPMC_PAR_C2 = 3'h3,
        FPMC_PAR_C3 = 3'h4,
        FPMC_PAR_GAIN = 3'h5
    } fpmc_param_e;

    typedef enum logic [1:0] {
        FPMC_MODE_CURRENT = 2'h0,
        FPMC_MODE_POWER = 2'h1,
        FPMC_MODE_FAST = 2'h2
    } fpmc_mode_e;

    typedef enum logic [1:0] {
        FPMC_TGT_CURRENT = 2'h0,
        FPMC_TGT_PD_POWER = 2'h1,
        FPMC_TGT_PD_CURRENT = 2'h2
    } fpmc_target_e;
endpackage : fpmc_pkg
`default_nettype wire
